/* src/kpi_pkg.sv */
// Package for the keypad pin interrupt block: register map, fields, carriers.
// Assumes a 32-bit Avalon-MM word bus with word-aligned byte addresses.
package kpi_pkg;
   localparam int KPI_PINS      = 8;
   localparam int KPI_ADDR_W    = 4;
   localparam int KPI_DATA_W    = 32;
   localparam logic [KPI_ADDR_W-1:0] KPI_OFS_STATUS_CTRL = 4'h0;
   localparam logic [KPI_ADDR_W-1:0] KPI_OFS_PIN_ENABLE  = 4'h4;
   localparam logic [KPI_ADDR_W-1:0] KPI_OFS_BREAK_CTRL  = 4'h8;
   localparam int KPI_BIT_SENSE   = 0;
   localparam int KPI_BIT_MASK    = 1;
   localparam int KPI_BIT_ACK     = 2;
   localparam int KPI_BIT_PENDING = 3;
   localparam int KPI_BIT_BREAK_CLEAR_ENABLE    = 0;
   localparam logic [KPI_PINS-1:0]   KPI_PIN_ENABLE_RST = 8'h00;
   localparam logic [KPI_DATA_W-1:0] KPI_UNMAPPED_DATA  = 32'h0000_0000;

   typedef enum logic [1:0] {
      KPI_BUS_IDLE = 2'b00,
      KPI_BUS_ANS  = 2'b01
   } kpi_bus_state_t;

   typedef struct packed {
      logic                  read;
      logic                  write;
      logic [KPI_ADDR_W-1:0] address;
      logic [KPI_DATA_W-1:0] writedata;
   } kpi_bus_req_t;

   typedef struct packed {
      logic                  waitrequest;
      logic [KPI_DATA_W-1:0] readdata;
   } kpi_bus_rsp_t;
endpackage

/* src/kpi_keypad_irq.sv */
// Keypad pin interrupt unit: eight key lines, latched request, mask, pending flag.
// Assumes key pins are asynchronous, and CPU vector fetch, break and low-power
// status arrive as signals on sys_clk_in.
//
// Summary of operation
// - Each enable bit makes its line a keypad interrupt input; cleared bit excludes it.
// - An enabled line also turns on its internal pullup.
// - Request latches when an enabled line falls while all enabled lines were high.
// - Edge-only mode ignores a fall while another enabled line is already low.
// - Sense select 1 is edge plus level, 0 is edge only.
// - Level mode clears only after acknowledge and all lines high, any order.
// - Level mode keeps the request pending while any enabled line is low.
// - A vector fetch acknowledges the request, subject to the level condition.
// - Writing 1 to the acknowledge bit acknowledges too; it always reads 0.
// - A fall after an acknowledge latches a fresh request.
// - Unmasked pending request interrupts the CPU through the keypad vector.
// - Edge-only mode clears at once on acknowledge, whatever the line levels.
// - Reset clears request, flag and sense select, even with a line low.
// - Pending flag reads the request regardless of the mask.
// - Enabled lines are forced to inputs; reads give the pin only if direction is 0.
// - Mask bit 1 stops the CPU interrupt; reset clears it.
// - Detection runs in wait and stop; unmasked request wakes the processor.
// - In break, a written acknowledge is ignored unless break clear enable is 1; then it sticks. A vector fetch still acknowledges.
// - Status register bits 7 to 4 read as 0.
`timescale 1ns/1ps
module kpi_keypad_irq
   import kpi_pkg::*;
#(
   parameter int PINS = KPI_PINS
) (
   input  wire logic            sys_clk_in,
   input  wire logic            rst_n_in,
   input  wire logic [3:0]      avs_address_in,
   input  wire logic            avs_read_in,
   input  wire logic            avs_write_in,
   input  wire logic [31:0]     avs_writedata_in,
   input  wire logic [3:0]      avs_byteenable_in,
   output logic      [31:0]     avs_readdata_out,
   output logic                 avs_waitrequest_out,
   input  wire logic [PINS-1:0] key_pin_in,
   input  wire logic [PINS-1:0] port_direction_bits_in,
   input  wire logic [PINS-1:0] port_data_latch_in,
   input  wire logic            vector_fetch_in,
   input  wire logic            break_state_in,
   input  wire logic            low_power_in,
   output logic      [PINS-1:0] pullup_enable_out,
   output logic      [PINS-1:0] port_direction_eff_out,
   output logic      [PINS-1:0] port_read_value_out,
   output logic                 cpu_irq_out,
   output logic                 wake_out
);
   logic [PINS-1:0] sync1_reg;
   logic [PINS-1:0] sync2_reg;
   logic [PINS-1:0] pin_enable_reg;
   logic            sense_select_reg;
   logic            irq_mask_bit_reg;
   logic            break_clear_enable_reg;
   logic            request_reg;
   logic            request_next;
   // Level mode: an acknowledge taken while a line is still low waits here
   logic            ack_seen_reg;
   logic            ack_seen_next;
   logic            all_high_prev_reg;
   logic [31:0]     readdata_reg;
   kpi_bus_state_t  bus_state_reg;

   // Two flops per line; only sync2 feeds detection
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_reg <= '1;
         sync2_reg <= '1;
      end else begin
         sync1_reg <= key_pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   wire [PINS-1:0] enabled_low = pin_enable_reg & ~sync2_reg;
   wire            any_low     = |enabled_low;
   wire            all_high    = ~any_low;
   // Latch only on the transition from all high to some low
   wire            fall_event  = any_low && all_high_prev_reg;

   // One-cycle answer: waitrequest is high on the request cycle, low the next
   wire req_active = (avs_read_in || avs_write_in) && (bus_state_reg == KPI_BUS_IDLE);
   wire wr_take    = avs_write_in && (bus_state_reg == KPI_BUS_ANS);
   wire rd_take    = avs_read_in && (bus_state_reg == KPI_BUS_ANS);
   wire sel_sc     = (avs_address_in == KPI_OFS_STATUS_CTRL);
   wire sel_pe     = (avs_address_in == KPI_OFS_PIN_ENABLE);
   wire sel_bk     = (avs_address_in == KPI_OFS_BREAK_CTRL);
   wire lane0      = avs_byteenable_in[0];

   wire ack_write  = wr_take && sel_sc && lane0 && avs_writedata_in[KPI_BIT_ACK];
   // Break protects the flag from written acknowledges unless clearing is allowed; a clear then sticks
   wire ack_allow  = !break_state_in || break_clear_enable_reg;
   wire ack        = vector_fetch_in || (ack_write && ack_allow);

   always_comb begin
      request_next  = request_reg;
      ack_seen_next = ack_seen_reg;
      if (ack && !sense_select_reg) begin
         request_next  = 1'b0;
         ack_seen_next = 1'b0;
      end else if (ack || ack_seen_reg) begin
         if (any_low) begin
            ack_seen_next = request_reg;
         end else begin
            request_next  = 1'b0;
            ack_seen_next = 1'b0;
         end
      end
      // A new fall in the same cycle as an acknowledge wins
      if (fall_event) begin
         request_next  = 1'b1;
         ack_seen_next = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         request_reg       <= 1'b0;
         ack_seen_reg      <= 1'b0;
         all_high_prev_reg <= 1'b1;
      end else begin
         request_reg       <= request_next;
         ack_seen_reg      <= ack_seen_next;
         all_high_prev_reg <= all_high;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_enable_reg         <= KPI_PIN_ENABLE_RST;
         sense_select_reg       <= 1'b0;
         irq_mask_bit_reg       <= 1'b0;
         break_clear_enable_reg <= 1'b0;
      end else if (wr_take && lane0) begin
         if (sel_sc) begin
            sense_select_reg <= avs_writedata_in[KPI_BIT_SENSE];
            irq_mask_bit_reg <= avs_writedata_in[KPI_BIT_MASK];
         end else if (sel_pe) begin
            pin_enable_reg <= avs_writedata_in[PINS-1:0];
         end else if (sel_bk) begin
            break_clear_enable_reg <= avs_writedata_in[KPI_BIT_BREAK_CLEAR_ENABLE];
         end
      end
   end

   // Read data; the status ack bit and status bits 7..4 are never set
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = KPI_UNMAPPED_DATA;
      if (sel_sc) begin
         rd_mux[KPI_BIT_SENSE]   = sense_select_reg;
         rd_mux[KPI_BIT_MASK]    = irq_mask_bit_reg;
         rd_mux[KPI_BIT_PENDING] = request_reg;
      end else if (sel_pe) begin
         rd_mux[PINS-1:0] = pin_enable_reg;
      end else if (sel_bk) begin
         rd_mux[KPI_BIT_BREAK_CLEAR_ENABLE] = break_clear_enable_reg;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_state_reg <= KPI_BUS_IDLE;
         readdata_reg  <= KPI_UNMAPPED_DATA;
      end else begin
         if (req_active)
            bus_state_reg <= KPI_BUS_ANS;
         else
            bus_state_reg <= KPI_BUS_IDLE;
         if (req_active && avs_read_in)
            readdata_reg <= rd_mux;
      end
   end

   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !(rd_take || wr_take);
   assign avs_readdata_out    = readdata_reg;

   assign pullup_enable_out      = pin_enable_reg;
   assign port_direction_eff_out = port_direction_bits_in & ~pin_enable_reg;
   assign port_read_value_out    = (port_direction_bits_in & port_data_latch_in)
                                 | (~port_direction_bits_in & sync2_reg);
   assign cpu_irq_out = request_reg && !irq_mask_bit_reg;
   assign wake_out    = cpu_irq_out && low_power_in;
endmodule

/* test/kpi_irq_assertions.sv */
// Port checker for the keypad interrupt unit.
// Assumes it is bound into kpi_keypad_irq and sees only its ports.
`timescale 1ns/1ps
module kpi_irq_assertions
   import kpi_pkg::*;
(
   input wire logic        sys_clk_in,
   input wire logic        rst_n_in,
   input wire logic [3:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic        avs_waitrequest_out,
   input wire logic [31:0] avs_readdata_out,
   input wire logic [7:0]  port_direction_bits_in,
   input wire logic        low_power_in,
   input wire logic [7:0]  pullup_enable_out,
   input wire logic [7:0]  port_direction_eff_out,
   input wire logic        cpu_irq_out,
   input wire logic        wake_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   wire        done = avs_read_in && !avs_waitrequest_out;
   wire        stat = done && avs_address_in == KPI_OFS_STATUS_CTRL;
   wire [31:0] q    = avs_readdata_out;
   dir_force_a: assert property (
      port_direction_eff_out == (port_direction_bits_in & ~pullup_enable_out)) else $error("dir");
   wake_gate_a: assert property (wake_out == (cpu_irq_out && low_power_in))
      else $error("wake");
   stat_zero_a: assert property (stat |-> (q & 32'hffff_fff4) == 32'h0)
      else $error("zero bits");
   en_pull_a: assert property (done && avs_address_in == KPI_OFS_PIN_ENABLE |->
      q[7:0] == pullup_enable_out) else $error("pullup");
   en_hold_a: assert property ($changed(pullup_enable_out) |-> $past(avs_write_in))
      else $error("enable");
   mask_stop_a: assert property (stat && q[KPI_BIT_MASK] |-> !cpu_irq_out)
      else $error("mask");
   pend_irq_a: assert property (stat && !q[KPI_BIT_MASK] |->
      cpu_irq_out == q[KPI_BIT_PENDING]) else $error("pending");
   reset_clear_a: assert property ($rose(rst_n_in) |-> !cpu_irq_out && !pullup_enable_out)
      else $error("reset");
endmodule
bind kpi_keypad_irq kpi_irq_assertions i_kpi_irq_assertions (.sys_clk_in, .rst_n_in,
   .avs_address_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out, .avs_readdata_out,
   .port_direction_bits_in, .low_power_in, .pullup_enable_out, .port_direction_eff_out,
   .cpu_irq_out, .wake_out);

/* test/kpi_key_model.sv */
// Key switches: a pressed key pulls its line low.
// Assumes the unit's pullup output holds released lines high.
`timescale 1ns/1ps
module kpi_key_model (
   input  wire logic       sys_clk_in,
   input  wire logic [7:0] press_in,
   input  wire logic [7:0] pullup_in,
   output logic      [7:0] line_out
);
   logic [7:0] wander = 8'h55;
   // Unpulled lines toggle so a missing pullup cannot pass by luck
   always @(posedge sys_clk_in) wander <= ~wander;
   assign line_out = ~press_in & (pullup_in | wander);
endmodule

/* test/kpi_keypad_irq_tb_top.sv */
// Bench for the keypad unit: Avalon-MM register tasks and key scenarios.
// Assumes the key model and the bound checker; one clock.
`timescale 1ns/1ps
module kpi_keypad_irq_tb_top import kpi_pkg::*; ;
   logic clk = 0, rst_n = 0, rd = 0, wr = 0, vf = 0, brk = 0, lp = 0, wt, irq;
   logic [3:0]  adr = 0;
   logic [31:0] wd = 0, rdata, q;
   logic [7:0]  press = 0, pull, pins;
   int          err_total = 0, num_checks = 0, cyc = 0;
   always #2 clk = ~clk;
   kpi_keypad_irq i_kpi_keypad_irq (.sys_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'h1),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wt), .key_pin_in(pins),
      .port_direction_bits_in(8'hff), .port_data_latch_in(8'ha5), .vector_fetch_in(vf),
      .break_state_in(brk), .low_power_in(lp), .pullup_enable_out(pull),
      .port_direction_eff_out(), .port_read_value_out(), .cpu_irq_out(irq), .wake_out());
   kpi_key_model i_kpi_key_model (.sys_clk_in(clk), .press_in(press), .pullup_in(pull),
      .line_out(pins));
   task automatic close_out;
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      adr <= a;
      wd <= d;
      do @(posedge clk); while (wt !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic rc(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      num_checks++;
      if (q !== e) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, q, e);
      end
   endtask
   task automatic key(input logic [7:0] p);
      @(posedge clk) press <= p;
      repeat (5) @(posedge clk);
   endtask
   task automatic t_regs;
      rc(4'h0, 32'h0);
      rc(4'h4, 32'h0);
      rc(4'hc, KPI_UNMAPPED_DATA);
      bus(1'b1, 4'h0, 32'hff);
      rc(4'h0, 32'h3);
      $display("t_regs done");
   endtask
   task automatic t_edge;
      bus(1'b1, 4'h0, 32'h2);
      bus(1'b1, 4'h4, 32'hfe);
      bus(1'b1, 4'h0, 32'h6);
      bus(1'b1, 4'h0, 32'h0);
      key(8'h01);
      rc(4'h0, 32'h0);
      key(8'h03);
      rc(4'h0, 32'h8);
      bus(1'b1, 4'h0, 32'h4);
      rc(4'h0, 32'h0);
      key(8'h07);
      rc(4'h0, 32'h0);
      key(8'h00);
      key(8'h04);
      rc(4'h0, 32'h8);
      @(posedge clk) vf <= 1'b1;
      @(posedge clk) vf <= 1'b0;
      rc(4'h0, 32'h0);
      bus(1'b1, 4'h0, 32'h2);
      key(8'h00);
      key(8'h10);
      rc(4'h0, 32'ha);
      key(8'h00);
      $display("t_edge done");
   endtask
   task automatic t_level;
      bus(1'b1, 4'h0, 32'h5);
      key(8'h20);
      bus(1'b1, 4'h0, 32'h5);
      rc(4'h0, 32'h9);
      key(8'h00);
      rc(4'h0, 32'h1);
      key(8'h20);
      key(8'h00);
      rc(4'h0, 32'h9);
      bus(1'b1, 4'h0, 32'h5);
      rc(4'h0, 32'h1);
      $display("t_level done");
   endtask
   task automatic t_break;
      bus(1'b1, 4'h0, 32'h0);
      key(8'h40);
      @(posedge clk) brk <= 1'b1;
      bus(1'b1, 4'h0, 32'h4);
      rc(4'h0, 32'h8);
      bus(1'b1, 4'h8, 32'h1);
      rc(4'h8, 32'h1);
      bus(1'b1, 4'h0, 32'h4);
      @(posedge clk) brk <= 1'b0;
      rc(4'h0, 32'h0);
      $display("t_break done");
   endtask
   task automatic t_reset;
      bus(1'b1, 4'h0, 32'h1);
      key(8'h00);
      key(8'h80);
      rc(4'h0, 32'h9);
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rc(4'h0, 32'h0);
      rc(4'h4, 32'h0);
      $display("t_reset done");
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      lp <= 1'b1;
      t_regs();
      t_edge();
      t_level();
      t_break();
      t_reset();
      close_out();
   end
endmodule
